/* rtl/indicator_defs.vh */
// Purpose: Constants for the scanner status indicator block
// Assumes: 100 MHz ref_clk
// Notes:   Included by blink_gen, status_indicator, the monitor and the bench top; not by sync2
`ifndef INDICATOR_DEFS_VH
`define INDICATOR_DEFS_VH

// Operating modes
`define MODE_START        3'h0
`define MODE_READING      3'h1
`define MODE_PERCENT      3'h2
`define MODE_READ_RATE    3'h3
`define MODE_PROFILE      3'h4
`define MODE_AUTOSETUP    3'h5

// Trigger sources
`define TRIG_REFLECTOR    2'h0
`define TRIG_SENSOR       2'h1
`define TRIG_FREE_RUN     2'h2
`define TRIG_HOST_CMD     2'h3

// Switching output event functions
`define EVT_NONE          3'h0
`define EVT_GOOD_READ     3'h1
`define EVT_NO_READ       3'h2
`define EVT_MATCH         3'h3
`define EVT_NO_MATCH      3'h4
`define EVT_INTERVAL      3'h5
`define EVT_TEACH_DONE    3'h6

// Beeper function reset value: good read
`define BEEP_FN_RESET     3'h1

// Read-rate thresholds in percent
`define RATE_LOW          7'h1E
`define RATE_MID          7'h46
`define RATE_HIGH         7'h5A

// Reflector polling: lamp on one scan in this many
`define POLL_SCAN_DIV     5'h14

// Timing
`define CLK_HZ            100000000
`define BLINK_SLOW_HZ     2
`define BLINK_FAST_HZ     5
`define DATA_FLICKER_HZ   20
`define BEEP_PULSE_MS     50

`endif

/* rtl/sync2.v */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Single clock ref_clk, synchronous reset
// Notes:   First stage read only by second stage
`timescale 1ns/1ns
module sync2 #(
	parameter WIDTH = 1
) (
	ref_clk,
	rst,
	d,
	q
);
	input  wire             ref_clk;
	input  wire             rst;
	input  wire [WIDTH-1:0] d;
	output reg  [WIDTH-1:0] q;

	reg [WIDTH-1:0] meta_reg;

	always @(posedge ref_clk) begin
		if (rst) begin
			meta_reg <= {WIDTH{1'b0}};
			q        <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

/* rtl/blink_gen.v */
// Purpose: Square wave at a set frequency, about equal on and off
// Assumes: ref_clk at CLK_FREQ
// Notes:   Toggles every half period
`timescale 1ns/1ns
`include "indicator_defs.vh"
module blink_gen #(
	parameter FREQ_HZ  = 2,
	parameter CNT_W    = 26,
	parameter CLK_FREQ = `CLK_HZ
) (
	ref_clk,
	rst,
	wave
);
	input  wire ref_clk;
	input  wire rst;
	output reg  wave;

	localparam integer HALF = CLK_FREQ / (2 * FREQ_HZ);
	localparam [CNT_W-1:0] HALF_M1 = HALF[CNT_W-1:0] - 1'b1;

	reg [CNT_W-1:0] cnt_reg;

	always @(posedge ref_clk) begin
		if (rst) begin
			cnt_reg <= {CNT_W{1'b0}};
			wave    <= 1'b0;
		end else if (cnt_reg == HALF_M1) begin
			cnt_reg <= {CNT_W{1'b0}};
			wave    <= ~wave;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule

/* rtl/status_indicator.v */
// Purpose: Status lamps, trigger, teach and switching outputs of a reader
// Assumes: Mode, decode and host events come from logic on ref_clk;
//          sensor_1_in and sensor_2_in are pins
// Notes:
`timescale 1ns/1ns
`include "indicator_defs.vh"
module status_indicator #(
	parameter BEEP_CYCLES = `CLK_HZ / 1000 * `BEEP_PULSE_MS,
	parameter CLK_FREQ    = `CLK_HZ
) (
	ref_clk,
	rst,
	mode,
	self_test_ok,
	profile_wait_done,
	trig_sel,
	continuous_read,
	sensor_1_in,
	sensor_2_in,
	host_trig_start,
	host_trig_stop,
	scan_tick,
	decode_done,
	decode_good,
	match_enable,
	match_hit,
	read_rate,
	host_tx_busy,
	result_fn_0,
	result_fn_1,
	result_fn_2,
	beep_fn,
	error_status_en,
	reflector_seen,
	ready_lamp,
	laser_lamp,
	result_lamp,
	data_lamp,
	laser_on,
	reading_interval,
	teach_req,
	result_out,
	beep_out,
	error_status_field
);
	input  wire       ref_clk;
	input  wire       rst;
	input  wire [2:0] mode;
	input  wire       self_test_ok;
	input  wire       profile_wait_done;
	input  wire [1:0] trig_sel;
	input  wire       continuous_read;
	input  wire       sensor_1_in;
	input  wire       sensor_2_in;
	input  wire       host_trig_start;
	input  wire       host_trig_stop;
	input  wire       scan_tick;
	input  wire       decode_done;
	input  wire       decode_good;
	input  wire       match_enable;
	input  wire       match_hit;
	input  wire [6:0] read_rate;
	input  wire       host_tx_busy;
	input  wire [2:0] result_fn_0;
	input  wire [2:0] result_fn_1;
	input  wire [2:0] result_fn_2;
	input  wire [2:0] beep_fn;
	input  wire       error_status_en;
	input  wire       reflector_seen;
	output reg        ready_lamp;
	output reg        laser_lamp;
	output reg        result_lamp;
	output reg        data_lamp;
	output reg        laser_on;
	output reg        reading_interval;
	output reg        teach_req;
	output reg  [2:0] result_out;
	output reg        beep_out;
	output reg        error_status_field;

	localparam BEEP_W = 24;
	localparam [BEEP_W-1:0] BEEP_LEN = BEEP_CYCLES[BEEP_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and blink sources
	wire sensor_1_s;
	wire sensor_2_s;
	wire blink_slow;
	wire blink_fast;
	wire flicker;

	sync2 #(.WIDTH(2)) u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       ({sensor_2_in, sensor_1_in}),
		.q       ({sensor_2_s, sensor_1_s})
	);

	blink_gen #(.FREQ_HZ(`BLINK_SLOW_HZ), .CLK_FREQ(CLK_FREQ)) u_slow (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wave    (blink_slow)
	);

	blink_gen #(.FREQ_HZ(`BLINK_FAST_HZ), .CLK_FREQ(CLK_FREQ)) u_fast (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wave    (blink_fast)
	);

	blink_gen #(.FREQ_HZ(`DATA_FLICKER_HZ), .CLK_FREQ(CLK_FREQ)) u_flick (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wave    (flicker)
	);

	////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire in_reading = (mode == `MODE_READING);
	wire in_eval    = (mode == `MODE_PERCENT) || (mode == `MODE_READ_RATE);
	wire in_free    = (mode == `MODE_PROFILE) || (mode == `MODE_AUTOSETUP);
	wire in_start   = (mode == `MODE_START);
	wire free_trig  = (trig_sel == `TRIG_FREE_RUN) || continuous_read;

	////////////////////////////////////////////////////////////////////////
	// Reading interval
	reg sensor_1_d_reg;
	reg sensor_2_d_reg;
	reg interval_next;
	reg interval_d_reg;

	always @* begin
		interval_next = reading_interval;
		if (!in_reading)
			interval_next = 1'b0;
		else begin
			case (trig_sel)
			`TRIG_REFLECTOR: interval_next = ~reflector_seen;
			`TRIG_SENSOR:    interval_next = sensor_1_s;
			`TRIG_FREE_RUN:  interval_next = 1'b1;
			`TRIG_HOST_CMD: begin
				if (host_trig_start)
					interval_next = 1'b1;
				else if (host_trig_stop)
					interval_next = 1'b0;
			end
			default:         interval_next = 1'b0;
			endcase
			if (continuous_read)
				interval_next = 1'b1;
		end
	end

	wire interval_end = interval_d_reg && !reading_interval;

	always @(posedge ref_clk) begin
		if (rst) begin
			reading_interval <= 1'b0;
			interval_d_reg   <= 1'b0;
			sensor_1_d_reg   <= 1'b0;
			sensor_2_d_reg   <= 1'b0;
			teach_req        <= 1'b0;
		end else begin
			reading_interval <= interval_next;
			interval_d_reg   <= reading_interval;
			sensor_1_d_reg   <= sensor_1_s;
			sensor_2_d_reg   <= sensor_2_s;
			teach_req        <= sensor_2_s && !sensor_2_d_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Laser and emitter lamp
	reg [4:0] scan_cnt_reg;
	always @(posedge ref_clk) begin
		if (rst)
			scan_cnt_reg <= 5'h00;
		else if (scan_tick) begin
			if (scan_cnt_reg == `POLL_SCAN_DIV - 5'h01)
				scan_cnt_reg <= 5'h00;
			else
				scan_cnt_reg <= scan_cnt_reg + 5'h01;
		end
	end

	reg laser_next;
	reg laser_lamp_next;

	always @* begin
		laser_next      = 1'b0;
		laser_lamp_next = 1'b0;
		if (in_start) begin
			laser_next      = !profile_wait_done;
			laser_lamp_next = !profile_wait_done;
		end else if (in_eval || in_free) begin
			laser_next      = 1'b1;
			laser_lamp_next = 1'b1;
		end else if (in_reading) begin
			if (free_trig) begin
				laser_next      = 1'b1;
				laser_lamp_next = 1'b1;
			end else if (trig_sel == `TRIG_REFLECTOR
					&& !reading_interval) begin
				laser_next      = 1'b1;
				laser_lamp_next = (scan_cnt_reg == 5'h00);
			end else begin
				laser_next      = reading_interval;
				laser_lamp_next = reading_interval;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			laser_on   <= 1'b0;
			laser_lamp <= 1'b0;
		end else begin
			laser_on   <= laser_next;
			laser_lamp <= laser_lamp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outcome lamp
	wire good_ok = decode_done && decode_good
		&& (!match_enable || match_hit);
	reg  hold_reg;
	reg  arm_reg;
	reg  result_next;
	// Lamp holds until the end of the pulse after the good read
	always @(posedge ref_clk) begin
		if (rst || !in_reading) begin
			hold_reg <= 1'b0;
			arm_reg  <= 1'b0;
		end else if (good_ok) begin
			hold_reg <= 1'b1;
			arm_reg  <= 1'b0;
		end else if (hold_reg && reading_interval && !interval_d_reg)
			arm_reg  <= 1'b1;
		else if (hold_reg && arm_reg && interval_end) begin
			hold_reg <= 1'b0;
			arm_reg  <= 1'b0;
		end
	end

	always @* begin
		result_next = 1'b0;
		if (in_eval) begin
			if (read_rate > `RATE_HIGH)
				result_next = 1'b1;
			else if (read_rate >= `RATE_MID)
				result_next = blink_fast;
			else if (read_rate >= `RATE_LOW)
				result_next = blink_slow;
		end else if (in_reading)
			result_next = hold_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Switching outputs, beeper, status lamps
	function evt_sel;
		input [2:0] fn;
		input       done;
		input       good;
		input       hit;
		input       ivl;
		input       teach;
		begin
			case (fn)
			`EVT_GOOD_READ:  evt_sel = done && good;
			`EVT_NO_READ:    evt_sel = done && !good;
			`EVT_MATCH:      evt_sel = done && good && hit;
			`EVT_NO_MATCH:   evt_sel = done && good && !hit;
			`EVT_INTERVAL:   evt_sel = ivl;
			`EVT_TEACH_DONE: evt_sel = teach;
			default:         evt_sel = 1'b0;
			endcase
		end
	endfunction

	reg [BEEP_W-1:0] beep_cnt_reg;
	wire beep_hit = evt_sel(beep_fn, decode_done, decode_good, match_hit,
		1'b0, teach_req);

	always @(posedge ref_clk) begin
		if (rst) begin
			result_out         <= 3'h0;
			beep_cnt_reg       <= {BEEP_W{1'b0}};
			beep_out           <= 1'b0;
			ready_lamp         <= 1'b0;
			data_lamp          <= 1'b0;
			result_lamp        <= 1'b0;
			error_status_field <= 1'b0;
		end else begin
			// No switching output signals in evaluation modes
			result_out[0] <= in_reading && evt_sel(result_fn_0,
				decode_done, decode_good, match_hit,
				reading_interval, teach_req);
			result_out[1] <= in_reading && evt_sel(result_fn_1,
				decode_done, decode_good, match_hit,
				reading_interval, teach_req);
			result_out[2] <= in_reading && evt_sel(result_fn_2,
				decode_done, decode_good, match_hit,
				reading_interval, teach_req);
			if (in_reading && beep_hit)
				beep_cnt_reg <= BEEP_LEN;
			else if (beep_cnt_reg != {BEEP_W{1'b0}})
				beep_cnt_reg <= beep_cnt_reg - 1'b1;
			beep_out    <= (beep_cnt_reg != {BEEP_W{1'b0}});
			ready_lamp  <= in_reading && self_test_ok
				&& profile_wait_done;
			data_lamp   <= host_tx_busy && flicker;
			result_lamp <= result_next;
			error_status_field <= error_status_en && (decode_done
				? !decode_good : error_status_field);
		end
	end
endmodule

/* tb/status_indicator_monitor.sv */
// Purpose: Port checker for status_indicator
// Assumes: One clock ref_clk, rst synchronous active high
// Notes:   Bound to every status_indicator instance
`timescale 1ns/1ns
`include "indicator_defs.vh"
module status_indicator_monitor #(
	parameter BEEP_CYCLES = 4
) (
	input wire       ref_clk,
	input wire       rst,
	input wire [2:0] mode,
	input wire       self_test_ok,
	input wire       profile_wait_done,
	input wire [1:0] trig_sel,
	input wire       sensor_2_in,
	input wire [6:0] read_rate,
	input wire       host_tx_busy,
	input wire       ready_lamp,
	input wire       laser_lamp,
	input wire       laser_on,
	input wire       result_lamp,
	input wire       data_lamp,
	input wire       teach_req,
	input wire [2:0] result_out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire rd   = mode == `MODE_READING;
	wire eval = mode == `MODE_PERCENT || mode == `MODE_READ_RATE;
	property p_rdy;
		rd && self_test_ok && profile_wait_done |=> ready_lamp;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready lamp off");
	property p_rdy_off;
		!(rd && self_test_ok && profile_wait_done) |=> !ready_lamp;
	endproperty
	a_rdy_off: assert property (p_rdy_off) else $error("ready lamp on");
	property p_free;
		(rd && trig_sel == `TRIG_FREE_RUN)[*3] |=> laser_on && laser_lamp;
	endproperty
	a_free: assert property (p_free) else $error("free run laser off");
	property p_eval;
		eval[*3] |=> laser_lamp;
	endproperty
	a_eval: assert property (p_eval) else $error("eval laser off");
	property p_hi;
		(eval && read_rate > `RATE_HIGH)[*2] |=> result_lamp;
	endproperty
	a_hi: assert property (p_hi) else $error("high rate lamp off");
	property p_lo;
		(eval && read_rate < `RATE_LOW)[*2] |=> !result_lamp;
	endproperty
	a_lo: assert property (p_lo) else $error("low rate lamp on");
	property p_data;
		!host_tx_busy |=> !data_lamp;
	endproperty
	a_data: assert property (p_data) else $error("data lamp idle on");
	property p_teach;
		$rose(sensor_2_in) |-> ##3 teach_req;
	endproperty
	a_teach: assert property (p_teach) else $error("teach late");
	property p_tpulse;
		teach_req |=> !teach_req;
	endproperty
	a_tpulse: assert property (p_tpulse) else $error("teach long");
	property p_quiet;
		(!rd)[*2] |=> result_out == 3'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("outputs not quiet");
endmodule
bind status_indicator status_indicator_monitor #(
	.BEEP_CYCLES(BEEP_CYCLES)
) u_mon (.*);

/* tb/field_devices.sv */
// Purpose: Trigger photo switch and teach key at the sensor pins
// Assumes: Commands from the bench
// Notes:   Pins change just after ref_clk rises
`timescale 1ns/1ns
module field_devices (
	input wire  ref_clk,
	input wire  obj_present,
	input wire  teach_press,
	output reg  sensor_1_in,
	output reg  sensor_2_in
);
	initial begin
		sensor_1_in = 1'b0;
		sensor_2_in = 1'b0;
	end
	always @(posedge ref_clk) begin
		sensor_1_in <= obj_present;
		sensor_2_in <= teach_press;
	end
endmodule

/* tb/status_indicator_tb_top.sv */
// Purpose: Directed bench for status_indicator
// Assumes: 100 MHz ref_clk, short beep length
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ns
`include "indicator_defs.vh"
module status_indicator_tb_top;
	localparam BEEP = 4;
	localparam SIM_HZ = 400; // Scaled clock rate for short blinks
	logic       ref_clk, rst, self_test_ok, profile_wait_done;
	logic       continuous_read, host_trig_start, host_trig_stop;
	logic       scan_tick, decode_done, decode_good, match_enable;
	logic       match_hit, host_tx_busy, error_status_en;
	logic       reflector_seen, obj, teach, s1, s2;
	logic       ready_lamp, laser_lamp, result_lamp, data_lamp;
	logic       laser_on, reading_interval, teach_req, beep_out;
	logic       error_status_field;
	logic [2:0] mode, result_fn_0, result_fn_1, result_fn_2, beep_fn;
	logic [2:0] result_out;
	logic [1:0] trig_sel;
	logic [6:0] read_rate;
	int         fail_count, n_compared, i, j, k;
	field_devices u_field (.ref_clk(ref_clk), .obj_present(obj),
		.teach_press(teach), .sensor_1_in(s1), .sensor_2_in(s2));
	status_indicator #(.BEEP_CYCLES(BEEP), .CLK_FREQ(SIM_HZ)) dut (
		.ref_clk(ref_clk), .rst(rst), .mode(mode),
		.self_test_ok(self_test_ok),
		.profile_wait_done(profile_wait_done), .trig_sel(trig_sel),
		.continuous_read(continuous_read), .sensor_1_in(s1),
		.sensor_2_in(s2), .host_trig_start(host_trig_start),
		.host_trig_stop(host_trig_stop), .scan_tick(scan_tick),
		.decode_done(decode_done), .decode_good(decode_good),
		.match_enable(match_enable), .match_hit(match_hit),
		.read_rate(read_rate), .host_tx_busy(host_tx_busy),
		.result_fn_0(result_fn_0), .result_fn_1(result_fn_1),
		.result_fn_2(result_fn_2), .beep_fn(beep_fn),
		.error_status_en(error_status_en),
		.reflector_seen(reflector_seen), .ready_lamp(ready_lamp),
		.laser_lamp(laser_lamp), .result_lamp(result_lamp),
		.data_lamp(data_lamp), .laser_on(laser_on),
		.reading_interval(reading_interval), .teach_req(teach_req),
		.result_out(result_out), .beep_out(beep_out),
		.error_status_field(error_status_field));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic decode(input logic g, input logic h);
		decode_good = g;
		match_hit = h;
		decode_done = 1'b1;
		cyc(1);
		decode_done = 1'b0;
	endtask
	// Counts high samples and toggles of one lamp
	task automatic watch(input logic pick);
		logic prev, cur;
		prev = pick ? data_lamp : result_lamp;
		k = 0;
		j = 0;
		repeat (SIM_HZ) begin
			cyc(1);
			cur = pick ? data_lamp : result_lamp;
			k += cur;
			j += (cur != prev);
			prev = cur;
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#1000000;
		fail_count++;
		tally_and_finish;
	end
	initial begin
		{self_test_ok, profile_wait_done, continuous_read} = 3'h0;
		{host_trig_start, host_trig_stop, scan_tick, decode_done} = 4'h0;
		{decode_good, match_enable, match_hit, host_tx_busy} = 4'h0;
		{error_status_en, reflector_seen, obj, teach} = 4'h0;
		{fail_count, n_compared} = 0;
		mode = `MODE_START;
		trig_sel = `TRIG_FREE_RUN;
		read_rate = 7'h00;
		result_fn_0 = `EVT_INTERVAL;
		result_fn_1 = `EVT_NONE;
		result_fn_2 = `EVT_GOOD_READ;
		beep_fn = `BEEP_FN_RESET;
		rst = 1'b1;
		cyc(3);
		chk("reset outs", {ready_lamp, laser_lamp, result_lamp,
			laser_on, reading_interval, teach_req}, 8'h00);
		rst = 1'b0;
		self_test_ok = 1'b1;
		cyc(4);
		chk("start laser", laser_lamp, 1);
		chk("start ready", ready_lamp, 0);
		for (i = 0; i < 4; i++) begin
			mode = i[0] ? `MODE_PROFILE : `MODE_AUTOSETUP;
			if (i > 1)
				mode = i[0] ? `MODE_PERCENT : `MODE_READ_RATE;
			cyc(4);
			chk("mode laser", laser_lamp, 1);
		end
		profile_wait_done = 1'b1;
		mode = `MODE_READING;
		cyc(4);
		chk("ready", ready_lamp, 1);
		chk("free laser", {laser_on, laser_lamp}, 8'h03);
		trig_sel = `TRIG_SENSOR;
		continuous_read = 1'b1;
		cyc(4);
		chk("cont laser", laser_lamp, 1);
		continuous_read = 1'b0;
		self_test_ok = 1'b0;
		cyc(4);
		chk("no self test", {ready_lamp, reading_interval}, 8'h00);
		self_test_ok = 1'b1;
		obj = 1'b1;
		cyc(6);
		chk("sensor ivl", {reading_interval, laser_lamp}, 8'h03);
		chk("ivl out", result_out[0], 1);
		decode(1'b1, 1'b0);
		chk("good out", result_out, 8'h05);
		k = 0;
		for (i = 0; i < 4 * BEEP; i++) begin
			cyc(1);
			k += beep_out;
		end
		chk("beep len", k, BEEP);
		chk("good lamp", result_lamp, 1);
		obj = 1'b0;
		cyc(6);
		chk("laser off", laser_lamp, 0);
		chk("lamp held", result_lamp, 1);
		obj = 1'b1;
		cyc(6);
		chk("lamp next", result_lamp, 1);
		match_enable = 1'b1;
		error_status_en = 1'b1;
		result_fn_1 = `EVT_NO_READ;
		decode(1'b0, 1'b0);
		chk("no read out", result_out, 8'h03);
		cyc(3);
		chk("error field", error_status_field, 1);
		obj = 1'b0;
		cyc(6);
		chk("lamp cleared", result_lamp, 0);
		result_fn_1 = `EVT_NO_MATCH;
		result_fn_2 = `EVT_MATCH;
		obj = 1'b1;
		decode(1'b1, 1'b0);
		chk("miss out", result_out, 8'h02);
		cyc(3);
		chk("no match", result_lamp, 0);
		chk("error clear", error_status_field, 0);
		decode(1'b1, 1'b1);
		chk("hit out", result_out, 8'h05);
		cyc(3);
		chk("match", result_lamp, 1);
		obj = 1'b0;
		cyc(6);
		trig_sel = `TRIG_HOST_CMD;
		cyc(2);
		chk("host idle", reading_interval, 0);
		host_trig_start = 1'b1;
		cyc(1);
		host_trig_start = 1'b0;
		cyc(3);
		chk("host open", reading_interval, 1);
		host_trig_stop = 1'b1;
		cyc(1);
		host_trig_stop = 1'b0;
		cyc(3);
		chk("host close", reading_interval, 0);
		trig_sel = `TRIG_REFLECTOR;
		reflector_seen = 1'b1;
		k = 0;
		for (i = 0; i < 40; i++) begin
			scan_tick = 1'b1;
			cyc(1);
			scan_tick = 1'b0;
			cyc(3);
			k += laser_lamp;
		end
		chk("poll scans", k, 2);
		mode = `MODE_PERCENT;
		host_tx_busy = 1'b1;
		read_rate = 7'h5F;
		cyc(4);
		chk("rate high", result_lamp, 1);
		chk("eval ready", ready_lamp, 0);
		watch(1'b1);
		chk("data edges", j, 2 * `DATA_FLICKER_HZ);
		chk("data duty", k, SIM_HZ / 2);
		host_tx_busy = 1'b0;
		read_rate = 7'h1E;
		cyc(2);
		chk("data idle", data_lamp, 0);
		watch(1'b0);
		chk("slow edges", j, 2 * `BLINK_SLOW_HZ);
		chk("slow duty", k, SIM_HZ / 2);
		read_rate = 7'h5A;
		cyc(2);
		watch(1'b0);
		chk("fast edges", j, 2 * `BLINK_FAST_HZ);
		chk("fast duty", k, SIM_HZ / 2);
		read_rate = 7'h0A;
		cyc(4);
		chk("rate low", result_lamp, 0);
		chk("eval quiet", result_out, 0);
		teach = 1'b1;
		k = 0;
		for (i = 0; i < 8; i++) begin
			cyc(1);
			k += teach_req;
		end
		chk("teach", k, 1);
		tally_and_finish;
	end
endmodule
